// ===== rtl/cvs_pkg.sv
/*
  Package of the capacitive divider sequencer: register offsets, field
  positions, reset values, trigger codes and timing constants.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package cvs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Timebase presets: one instruction cycle and one conversion clock in ns
  localparam int unsigned INSTR_NS = 125;
  localparam int unsigned INSTR_CYC = (INSTR_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_NS = 1000;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned RES_BITS = 10;

  // Register word indices (byte address divided by four)
  localparam logic [3:0] OFS_CH1 = 4'h0;
  localparam logic [3:0] OFS_CH2 = 4'h1;
  localparam logic [3:0] OFS_SHARED = 4'h2;
  localparam logic [3:0] OFS_TRIG = 4'h3;
  localparam logic [3:0] OFS_RESH = 4'h4;
  localparam logic [3:0] OFS_RESL = 4'h5;
  localparam logic [3:0] OFS_PRE = 4'h6;
  localparam logic [3:0] OFS_ACQ = 4'h7;
  localparam logic [3:0] OFS_SEQ = 4'h8;
  localparam logic [3:0] OFS_RESH2 = 4'h9;
  localparam logic [3:0] OFS_RESL2 = 4'ha;
  localparam logic [3:0] OFS_STAT = 4'hb;

  // Channel control fields
  localparam int unsigned F_ENABLE = 0;
  localparam int unsigned F_BUSY = 1;
  localparam int unsigned F_CHS_LO = 2;
  // Shared config fields
  localparam int unsigned F_SYNC = 2;
  localparam int unsigned F_JUSTIFY = 7;
  localparam int unsigned F_TBASE = 4;
  // Sequence control: precharge polarity; trigger register: selector low bit
  localparam int unsigned F_POL = 0;
  localparam int unsigned F_TRIG_LO = 4;

  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_RISE = 3'h6;
  localparam logic [2:0] TRIG_FALL = 3'h7;

  localparam logic [7:0] RST_REG = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE = 4'h2,
    ST_ACQ = 4'h4,
    ST_CONV = 4'h8
  } cvs_state_e;

  // Pin and mux overrides of one converter
  typedef struct packed {
    logic drive_en;
    logic drive_level;
    logic mux_open;
    logic hold_to_rail;
    logic hold_rail_high;
    logic hold_connect;
  } cvs_pin_s;
endpackage : cvs_pkg

// ===== rtl/cvs_sequencer.sv
/*
  Capacitive divider sequencer for two converters: start logic, precharge
  and acquisition timers, pin/mux overrides, a bit-serial successive
  approximation controller and the register file on Avalon-MM.
  Assumes the analog comparator answer arrives synchronous to clock.
*/
// Overview of operation
// - Each measurement runs precharge, then acquisition, then conversion.
// - Precharge lasts 1 to 127 timebase cycles, as programmed.
// - Precharge is enabled only by a non-zero precharge length.
// - Precharge begins on own start, synchronized start, or special trigger.
// - A start with zero precharge length skips precharge.
// - Precharge ties the hold capacitor to a rail chosen by polarity.
// - Precharge drives the selected pin high or low by polarity.
// - The analog mux is forced open only during precharge.
// - Acquisition lasts 1 to 127 timebase cycles, as programmed.
// - Timed acquisition is enabled only by a non-zero acquisition length.
// - Acquisition follows precharge with no gap.
// - With zero precharge, acquisition begins directly on start.
// - Acquisition switches off the pin's digital drivers.
// - Acquisition connects the selected channel to the hold capacitor.
// - Start comes from own bit, synchronized bit, or trigger input.
// - A running sequence completes while enabled, halts if disabled.
// - The busy bit reads set throughout a conversion, whatever the source.
// - After acquisition the held voltage is converted to a result.
// - Completion clears busy, sets done flag, loads result registers.
// - Sync start sets both busy bits; it reads as their OR.
// - Trigger selector 111 falling edge, 110 rising edge, 000 none.
// - Early termination writes partial result, missing bits copy last bit.
`timescale 1ns/1ps
module cvs_sequencer
  import cvs_pkg::*;
#(
  parameter int unsigned NCONV = 2,
  parameter int unsigned CHS_W = 6
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [NCONV-1:0] special_trigger,
  input wire logic external_trigger_pin,
  input wire logic [NCONV-1:0] compare_high,
  output cvs_pin_s [NCONV-1:0] pin_ctrl,
  output logic [NCONV-1:0][CHS_W-1:0] channel_select,
  output logic [NCONV-1:0] conversion_done_flag
);

  // Register file
  logic [NCONV-1:0][7:0] chan_reg, next_chan_reg;
  logic [NCONV-1:0][6:0] pre_len, next_pre_len, acq_len, next_acq_len;
  logic [NCONV-1:0] pol, next_pol;
  logic [7:0] shared_reg, next_shared_reg;
  logic [2:0] trig_sel, next_trig_sel;
  logic [NCONV-1:0][RES_BITS-1:0] result, next_result;
  logic [NCONV-1:0] done_flag, next_done_flag;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [1:0] resp, next_resp;
  // Sequencer state
  cvs_state_e [NCONV-1:0] state, next_state;
  logic [NCONV-1:0][6:0] count, next_count;
  logic [NCONV-1:0][RES_BITS-1:0] sar, next_sar;
  logic [NCONV-1:0][3:0] bitpos, next_bitpos;
  logic [NCONV-1:0] lastbit, next_lastbit;
  logic ext_prev;
  logic [7:0] tdiv;
  logic tick;

  // Partial result: missing low bits copy the last decided bit
  function automatic logic [RES_BITS-1:0] fill_partial(input logic [RES_BITS-1:0] v,
      input logic [3:0] pos, input logic last);
    logic [RES_BITS-1:0] r;
    r = v;
    for (int i = 0; i < RES_BITS; i++) begin
      if (i <= int'(pos)) begin
        r[i] = last;
      end
    end
    return r;
  endfunction : fill_partial

  // Justified result bytes
  function automatic logic [7:0] res_byte(input logic [RES_BITS-1:0] v, input logic hi,
      input logic just);
    if (just) begin
      return hi ? {6'h00, v[9:8]} : v[7:0];
    end
    return hi ? v[9:2] : {v[1:0], 6'h00};
  endfunction : res_byte

  // Timebase enable: instruction cycle or conversion clock, one pulse each period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tdiv <= 8'h00;
    end else if (tick) begin
      tdiv <= 8'h00;
    end else begin
      tdiv <= tdiv + 8'h01;
    end
  end
  assign tick = shared_reg[F_TBASE] ? (tdiv == 8'(CONV_CYC - 1)) : (tdiv == 8'(INSTR_CYC - 1));

  // Edge of the external trigger pin
  // Reset low matches the idle pin level, so no false edge follows reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= external_trigger_pin;
    end
  end

  logic wr, rd;
  logic [3:0] widx;
  logic auto_fire;
  // Writes land at the edge where waitrequest is seen low, not before
  assign wr = avs_write && ack;
  assign rd = avs_read && !ack;
  assign widx = avs_address[5:2];
  always_comb begin
    unique case (trig_sel)
      TRIG_RISE: auto_fire = external_trigger_pin && !ext_prev;
      TRIG_FALL: auto_fire = !external_trigger_pin && ext_prev;
      default: auto_fire = 1'b0;
    endcase
  end

  // Next values of registers and sequencers
  always_comb begin
    logic [NCONV-1:0] start, wr_busy_clr, busy;
    next_chan_reg = chan_reg;
    next_pre_len = pre_len;
    next_acq_len = acq_len;
    next_pol = pol;
    next_shared_reg = shared_reg;
    next_trig_sel = trig_sel;
    next_result = result;
    next_done_flag = done_flag;
    next_state = state;
    next_count = count;
    next_sar = sar;
    next_bitpos = bitpos;
    next_lastbit = lastbit;
    next_ack = avs_read || avs_write ? !ack : 1'b0;
    next_rdata = 32'h0000_0000;
    next_resp = 2'h0;
    start = '0;
    wr_busy_clr = '0;
    for (int c = 0; c < NCONV; c++) begin
      busy[c] = (state[c] != ST_IDLE);
    end
    if (wr && avs_byteenable[0]) begin
      unique case (widx)
        OFS_CH1, OFS_CH2: begin
          next_chan_reg[widx[0]] = {avs_writedata[7:2], 1'b0, avs_writedata[0]};
          start[widx[0]] = avs_writedata[F_BUSY];
          wr_busy_clr[widx[0]] = !avs_writedata[F_BUSY] && busy[widx[0]];
        end
        OFS_SHARED: begin
          next_shared_reg = {avs_writedata[7:3], 1'b0, avs_writedata[1:0]};
          if (avs_writedata[F_SYNC]) begin
            start = '1;
          end
        end
        OFS_TRIG: next_trig_sel = avs_writedata[6:4];
        OFS_PRE: next_pre_len[0] = avs_writedata[6:0];
        OFS_ACQ: next_acq_len[0] = avs_writedata[6:0];
        OFS_SEQ: next_pol = avs_writedata[1:0];
        OFS_RESH: next_result[0] = {avs_writedata[7:0], result[0][1:0]};
        OFS_RESL: next_result[0] = {result[0][9:2], avs_writedata[7:6]};
        OFS_STAT: next_done_flag = done_flag & ~avs_writedata[1:0];
        default: ;
      endcase
      // Second converter timers share the upper byte of the timer words
      if (avs_byteenable[1] && widx == OFS_PRE) begin
        next_pre_len[1] = avs_writedata[14:8];
      end
      if (avs_byteenable[1] && widx == OFS_ACQ) begin
        next_acq_len[1] = avs_writedata[14:8];
      end
    end
    // Unmapped writes flagged in the first cycle, so the code stands at the answer
    if (avs_write && !ack && widx > OFS_STAT) begin
      next_resp = 2'h2;
    end
    if (rd) begin
      unique case (widx)
        OFS_CH1, OFS_CH2: next_rdata = {24'h0, chan_reg[widx[0]][7:2], busy[widx[0]],
            chan_reg[widx[0]][0]};
        OFS_SHARED: next_rdata = {24'h0, shared_reg[7:3], |busy, shared_reg[1:0]};
        OFS_TRIG: next_rdata = {25'h0, trig_sel, 4'h0};
        OFS_PRE: next_rdata = {17'h0, pre_len[1], 1'b0, pre_len[0]};
        OFS_ACQ: next_rdata = {17'h0, acq_len[1], 1'b0, acq_len[0]};
        OFS_SEQ: next_rdata = {30'h0, pol};
        OFS_RESH: next_rdata = {24'h0, res_byte(result[0], 1'b1, shared_reg[F_JUSTIFY])};
        OFS_RESL: next_rdata = {24'h0, res_byte(result[0], 1'b0, shared_reg[F_JUSTIFY])};
        OFS_RESH2: next_rdata = {24'h0, res_byte(result[1], 1'b1, shared_reg[F_JUSTIFY])};
        OFS_RESL2: next_rdata = {24'h0, res_byte(result[1], 1'b0, shared_reg[F_JUSTIFY])};
        OFS_STAT: next_rdata = {30'h0, done_flag};
        default: next_resp = 2'h2;
      endcase
    end
    for (int c = 0; c < NCONV; c++) begin
      start[c] = (start[c] || special_trigger[c] || auto_fire) && chan_reg[c][F_ENABLE];
      unique case (state[c])
        ST_IDLE: begin
          if (start[c]) begin
            next_sar[c] = '0;
            next_bitpos[c] = 4'(RES_BITS - 1);
            if (pre_len[c] != 7'h00) begin
              next_state[c] = ST_PRE;
              next_count[c] = pre_len[c];
            end else if (acq_len[c] != 7'h00) begin
              next_state[c] = ST_ACQ;
              next_count[c] = acq_len[c];
            end else begin
              next_state[c] = ST_CONV;
            end
          end
        end
        ST_PRE: begin
          if (tick) begin
            next_count[c] = count[c] - 7'h01;
            if (count[c] == 7'h01) begin
              if (acq_len[c] != 7'h00) begin
                next_state[c] = ST_ACQ;
                next_count[c] = acq_len[c];
              end else begin
                next_state[c] = ST_CONV;
              end
            end
          end
        end
        ST_ACQ: begin
          if (tick) begin
            next_count[c] = count[c] - 7'h01;
            if (count[c] == 7'h01) begin
              next_state[c] = ST_CONV;
            end
          end
        end
        ST_CONV: begin
          // One result bit per timebase cycle, most significant first
          if (tick) begin
            next_sar[c][bitpos[c]] = compare_high[c];
            next_lastbit[c] = compare_high[c];
            next_bitpos[c] = bitpos[c] - 4'h1;
            if (bitpos[c] == 4'h0) begin
              next_state[c] = ST_IDLE;
              next_result[c] = sar[c] | RES_BITS'(compare_high[c]);
              next_done_flag[c] = 1'b1;
            end
          end
        end
        default: next_state[c] = ST_IDLE;
      endcase
      // Software clear of busy ends the sequence; the flag set wins
      if (wr_busy_clr[c]) begin
        next_state[c] = ST_IDLE;
        if (state[c] == ST_CONV) begin
          next_result[c] = fill_partial(sar[c], bitpos[c], lastbit[c]);
          next_done_flag[c] = 1'b1;
        end
      end
      if (!chan_reg[c][F_ENABLE]) begin
        next_state[c] = ST_IDLE;
      end
    end
  end

  // Register stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_reg <= '0;
      pre_len <= '0;
      acq_len <= '0;
      pol <= '0;
      shared_reg <= RST_REG;
      trig_sel <= TRIG_NONE;
      result <= '0;
      done_flag <= '0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      resp <= 2'h0;
      for (int c = 0; c < NCONV; c++) begin
        state[c] <= ST_IDLE;
      end
      count <= '0;
      sar <= '0;
      bitpos <= '0;
      lastbit <= '0;
    end else begin
      chan_reg <= next_chan_reg;
      pre_len <= next_pre_len;
      acq_len <= next_acq_len;
      pol <= next_pol;
      shared_reg <= next_shared_reg;
      trig_sel <= next_trig_sel;
      result <= next_result;
      done_flag <= next_done_flag;
      ack <= next_ack;
      rdata <= next_rdata;
      resp <= next_resp;
      state <= next_state;
      count <= next_count;
      sar <= next_sar;
      bitpos <= next_bitpos;
      lastbit <= next_lastbit;
    end
  end

  // Bus answers one cycle after the request is seen
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata = rdata;
  assign avs_response = resp;
  assign conversion_done_flag = done_flag;

  // Pin and mux overrides per stage
  always_comb begin
    for (int c = 0; c < NCONV; c++) begin
      channel_select[c] = chan_reg[c][7:F_CHS_LO];
      pin_ctrl[c].drive_en = (state[c] == ST_PRE);
      pin_ctrl[c].drive_level = pol[c];
      pin_ctrl[c].mux_open = (state[c] == ST_PRE);
      pin_ctrl[c].hold_to_rail = (state[c] == ST_PRE);
      pin_ctrl[c].hold_rail_high = !pol[c];
      pin_ctrl[c].hold_connect = (state[c] == ST_ACQ);
    end
  end

endmodule : cvs_sequencer

// ===== test/cvs_sensor_model.sv
/*
  Sensor pads and comparators facing the two converters.
  Assumes the pin override structs of cvs_sequencer and one clock.
*/
`timescale 1ns/1ps
module cvs_sensor_model
  import cvs_pkg::*;
(
  input wire logic clock,
  input wire cvs_pin_s [1:0] pin_ctrl,
  input wire logic [1:0] touched,
  output logic [1:0] compare_high
);
  logic [1:0] noise = 2'h1;
  // Answer is meaningless while the pad is forced, so it chatters there
  always_ff @(posedge clock) begin
    noise <= ~noise;
  end
  assign compare_high = touched ^ ({pin_ctrl[1].mux_open, pin_ctrl[0].mux_open} & noise);
endmodule : cvs_sensor_model

// ===== test/cvs_sequencer_props.sv
/*
  Checker of the sequencer: pin overrides, precharge bound, done flags, bus answer.
  Assumes it is bound to cvs_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module cvs_sequencer_props
  import cvs_pkg::*;
#(
  parameter int unsigned NCONV = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire cvs_pin_s [NCONV-1:0] pin_ctrl,
  input wire logic [NCONV-1:0] conversion_done_flag
);
  localparam int PRE_MAX = 127 * CONV_CYC;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Held off one cycle, then answered
  sequence s_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_answer: assert property ($rose(avs_read || avs_write) |-> s_ack)
    else $error("bus answer not one cycle after request");
  a_unmapped_resp: assert property ((avs_read || avs_write) && !avs_waitrequest
    && avs_address[5:2] > 4'hb |-> avs_response == 2'h2)
    else $error("unmapped access not flagged");
  for (genvar c = 0; c < NCONV; c++) begin : g_conv
    int unsigned pre_cnt;
    // Length of the running precharge window; a stuck timer shows here
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) pre_cnt <= 0;
      else pre_cnt <= pin_ctrl[c].mux_open ? pre_cnt + 1 : 0;
    end
    a_pre_drive: assert property (
      pin_ctrl[c].mux_open |-> pin_ctrl[c].drive_en && pin_ctrl[c].hold_to_rail
      && !pin_ctrl[c].hold_connect) else $error("precharge overrides missing");
    a_rail_polar: assert property (
      pin_ctrl[c].mux_open |-> pin_ctrl[c].hold_rail_high != pin_ctrl[c].drive_level)
      else $error("capacitor rail not opposite to pad");
    a_drive_window: assert property (
      pin_ctrl[c].drive_en == pin_ctrl[c].mux_open) else $error("drive outside precharge");
    a_drv_release: assert property (
      $fell(pin_ctrl[c].mux_open) |-> !pin_ctrl[c].drive_en && !pin_ctrl[c].hold_to_rail)
      else $error("drivers still on after precharge");
    a_acq_connect: assert property (
      pin_ctrl[c].hold_connect |-> !pin_ctrl[c].drive_en && !pin_ctrl[c].hold_to_rail)
      else $error("capacitor connected while biased");
    a_pre_bound: assert property (pre_cnt <= PRE_MAX)
      else $error("precharge longer than its longest setting");
    a_flag_clear: assert property (
      $fell(conversion_done_flag[c]) |-> $past(avs_write) && $past(avs_address[5:2]) == 4'hb)
      else $error("done flag dropped without a clear");
  end
endmodule : cvs_sequencer_props

bind cvs_sequencer cvs_sequencer_props #(.NCONV(NCONV)) i_props (.clock(clock),
  .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .pin_ctrl(pin_ctrl),
  .conversion_done_flag(conversion_done_flag));

// ===== test/cvs_sequencer_tb.sv
/*
  Testbench of cvs_sequencer: bus tasks and one task for each scenario.
  Assumes the sensor model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module cvs_sequencer_tb;
  import cvs_pkg::*;
  logic clock = 1'h0, resetn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic external_trigger_pin = 1'h0, avs_waitrequest;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0] special_trigger = 2'h0, touched = 2'h3, resp, avs_response;
  logic [1:0] compare_high, conversion_done_flag;
  cvs_pin_s [1:0] pin_ctrl;
  logic [1:0][5:0] channel_select;
  int miscompares = 0, total_checks = 0, cycles = 0;
  cvs_sequencer i_dut (.clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .special_trigger(special_trigger),
    .external_trigger_pin(external_trigger_pin), .compare_high(compare_high),
    .pin_ctrl(pin_ctrl), .channel_select(channel_select),
    .conversion_done_flag(conversion_done_flag));
  cvs_sensor_model i_pad (.clock(clock), .pin_ctrl(pin_ctrl), .touched(touched),
    .compare_high(compare_high));
  // 250 MHz
  always #2 clock = ~clock;
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= {idx, 2'h0};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("bus_answer", 32'h0, 32'h1);
    rd = avs_readdata;
    resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr
  task automatic rc(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(nm, exp, x);
  endtask : rc
  // Wait for converter 0 done, noting precharge and connection on the way
  task automatic watch(input int lim, output logic mx, output logic cn);
    int n;
    mx = 1'b0;
    cn = 1'b0;
    n = 0;
    while (conversion_done_flag[0] !== 1'b1 && n < lim) begin
      @(posedge clock);
      mx |= pin_ctrl[0].mux_open;
      cn |= pin_ctrl[0].hold_connect;
      n++;
    end
  endtask : watch
  task automatic t_regs();
    for (int i = 0; i < 12; i++) rc("reset_val", 4'(i), 32'h0);
    wr(4'hc, 32'hff);
    rc("unmapped", 4'hc, 32'h0);
    chk("unmapped_resp", 32'h2, 32'(resp));
  endtask : t_regs
  task automatic t_precharge();
    int n, m;
    logic mx, cn;
    n = 0;
    m = 0;
    wr(4'h0, 32'h15);
    wr(4'h6, 32'h2);
    wr(4'h7, 32'h3);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h17);
    chk("channel", 32'h5, 32'(channel_select[0]));
    while (pin_ctrl[0].mux_open !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk("pre_pin", 32'h3c, 32'(pin_ctrl[0]));
    while (pin_ctrl[0].mux_open === 1'b1 && m < 5000) begin
      @(posedge clock);
      m++;
    end
    chk("acq_pin", 32'h1, 32'(pin_ctrl[0]) & 32'h2d);
    chk("pre_len", 32'h1, 32'(m > INSTR_CYC && m <= 2 * INSTR_CYC + 2));
    rc("busy", 4'h0, 32'h17);
    rc("sync_or", 4'h2, 32'h4);
    watch(3000, mx, cn);
    rc("busy_clr", 4'h0, 32'h15);
    rc("res_h", 4'h4, 32'hff);
    rc("res_l", 4'h5, 32'hc0);
    wr(4'hb, 32'h3);
    rc("flag_clr", 4'hb, 32'h0);
  endtask : t_precharge
  task automatic t_skip();
    logic mx, cn;
    wr(4'h2, 32'h80);
    wr(4'h6, 32'h0);
    wr(4'h7, 32'h2);
    wr(4'h0, 32'h17);
    watch(3000, mx, cn);
    chk("skip_pre", 32'h0, 32'(mx));
    chk("direct_acq", 32'h1, 32'(cn));
    chk("done", 32'h1, 32'(conversion_done_flag[0]));
    rc("res_h_just", 4'h4, 32'h3);
    rc("res_l_just", 4'h5, 32'hff);
  endtask : t_skip
  task automatic t_abort();
    logic mx, cn;
    touched <= 2'h2;
    wr(4'h7, 32'h0);
    wr(4'hb, 32'h3);
    wr(4'h0, 32'h17);
    repeat (4 * INSTR_CYC) @(posedge clock);
    wr(4'h0, 32'h15);
    watch(3000, mx, cn);
    chk("abort_done", 32'h1, 32'(conversion_done_flag[0]));
    chk("no_pre", 32'h0, 32'(mx));
    rc("part_h", 4'h4, 32'h0);
    rc("part_l", 4'h5, 32'h0);
  endtask : t_abort
  task automatic t_sync();
    logic mx, cn;
    touched <= 2'h3;
    wr(4'h2, 32'h0);
    wr(4'h1, 32'h1);
    wr(4'h6, 32'h101);
    wr(4'h7, 32'h202);
    wr(4'hb, 32'h3);
    wr(4'h2, 32'h4);
    rc("sync_b1", 4'h0, 32'h17);
    rc("sync_b2", 4'h1, 32'h3);
    watch(3000, mx, cn);
    rc("sync_end", 4'h2, 32'h0);
    rc("res2_h", 4'h9, 32'hff);
    rc("res2_l", 4'ha, 32'hc0);
  endtask : t_sync
  task automatic t_disable();
    logic mx, cn;
    wr(4'hb, 32'h3);
    wr(4'h7, 32'h7f);
    wr(4'h0, 32'h17);
    wr(4'h0, 32'h0);
    rc("halted", 4'h0, 32'h0);
    watch(1000, mx, cn);
    chk("no_result", 32'h0, 32'(conversion_done_flag[0]));
  endtask : t_disable
  task automatic t_trig();
    logic [2:0] code [3] = '{TRIG_RISE, TRIG_FALL, TRIG_NONE};
    logic lvl [3] = '{1'b1, 1'b0, 1'b1};
    logic mx, cn;
    wr(4'h0, 32'h15);
    wr(4'h6, 32'h0);
    wr(4'h7, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(4'hb, 32'h3);
      wr(4'h3, {25'h0, code[i], 4'h0});
      rc("trig_sel", 4'h3, {25'h0, code[i], 4'h0});
      @(posedge clock);
      external_trigger_pin <= lvl[i];
      watch(1500, mx, cn);
      chk("trig_start", 32'(code[i] != 3'h0), 32'(conversion_done_flag[0]));
    end
    wr(4'hb, 32'h3);
    @(posedge clock);
    special_trigger <= 2'h1;
    @(posedge clock);
    special_trigger <= 2'h0;
    watch(1500, mx, cn);
    chk("special", 32'h1, 32'(conversion_done_flag[0]));
  endtask : t_trig
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_precharge();
    t_skip();
    t_abort();
    t_sync();
    t_disable();
    t_trig();
    end_of_test();
  end
endmodule : cvs_sequencer_tb
